// file: logic/ppw_pkg.sv
// constants for the peripheral power and converter input select registers
package ppw_pkg;
	// register map, 16-bit control port addresses
	localparam logic [15:0] PPW_ADDR_POWER = 16'hF051;
	localparam logic [15:0] PPW_ADDR_SEL_BASE = 16'hF100;
	localparam logic [15:0] PPW_ADDR_SEL_LAST = 16'hF107;
	localparam int PPW_NUM_SEL = 8;
	// reset values
	localparam logic [4:0] PPW_POWER_RESET = 5'h00;
	localparam logic [7:0] PPW_SEL_RESET = 8'h00;
	// power enable bit positions
	localparam int PPW_BIT_AUX_ADC = 0;
	localparam int PPW_BIT_SPDIF_RX = 1;
	localparam int PPW_BIT_SPDIF_TX = 2;
	localparam int PPW_BIT_MIC_LO = 3;
	localparam int PPW_BIT_MIC_HI = 4;
	localparam int PPW_POWER_W = 5;
	// selector fields
	localparam int PPW_SRC_LSB = 0;
	localparam int PPW_SRC_W = 3;
	localparam int PPW_PAIR_LSB = 3;
	localparam int PPW_PAIR_W = 5;
	localparam int PPW_SEL_W = 8;
	localparam logic [4:0] PPW_PAIR_MAX = 5'h17;
	// data widths of gated blocks
	localparam int PPW_MIC_CH = 4;
	localparam int PPW_MIC_W = 24;
	localparam int PPW_ADC_CH = 6;
	localparam int PPW_ADC_W = 10;
	localparam int PPW_RX_W = 24;
	// converter source codes
	typedef enum logic [2:0] {
		PPW_SRC_NONE = 3'h0,
		PPW_SRC_SERIAL = 3'h1,
		PPW_SRC_CORE = 3'h2,
		PPW_SRC_SPDIF = 3'h3,
		PPW_SRC_MIC_LO = 3'h4,
		PPW_SRC_MIC_HI = 3'h5
	} ppw_src_type;
endpackage

// file: logic/ppw_top.sv
// power enable and converter input select register bank with block gating
// Behaviour
// - the 5-bit power enable register sits at F051 and resets to zero, all blocks off.
// - bit 4 powers microphone channels 2 and 3; when clear their samples stop updating.
// - bit 3 powers microphone channels 0 and 1; when clear their samples freeze.
// - bit 2 powers the S/PDIF transmitter; when clear its output pin is held low.
// - bit 1 powers the S/PDIF receiver; when clear recovery halts until it is set again.
// - bit 0 powers the auxiliary ADCs; when clear their results hold the last value.
// - eight selectors at F100 to F107 reset to zero; selector n feeds converters 2n, 2n+1.
// - a selector can name serial inputs 0 to 47, microphones 0 to 3 or the S/PDIF receiver.
// - bits 2:0 are the source code: none, serial, core, S/PDIF, mic pair 0/1, mic pair 2/3.
// - with serial source, bits 7:3 value k routes serial channels 2k and 2k+1, k up to 23.
`timescale 1ns/1ps
module ppw_top
	import ppw_pkg::*;
(
	// clock and reset
	input wire logic CLK_SYS,
	input wire logic RST_N,
	// register port
	input wire logic [15:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [15:0] REG_RDATA,
	// power enables towards the gated blocks
	output logic MIC_PAIR_HI_POWER_EN,
	output logic MIC_PAIR_LO_POWER_EN,
	output logic SPDIF_TRANSMIT_POWER_EN,
	output logic SPDIF_RECEIVE_POWER_EN,
	output logic AUX_CONVERTER_POWER_EN,
	// microphone samples
	input wire logic [PPW_MIC_CH*PPW_MIC_W-1:0] MIC_DATA_IN,
	input wire logic [PPW_MIC_CH-1:0] MIC_VALID_IN,
	output logic [PPW_MIC_CH*PPW_MIC_W-1:0] MIC_DATA,
	// s/pdif transmitter
	input wire logic SPDIF_TX_LINE_IN,
	output logic SPDIF_TX_PIN,
	// s/pdif receiver
	input wire logic SPDIF_RX_PIN,
	input wire logic [PPW_RX_W-1:0] SPDIF_RX_DATA_IN,
	input wire logic SPDIF_RX_VALID_IN,
	output logic SPDIF_RX_STREAM,
	output logic [PPW_RX_W-1:0] SPDIF_RX_DATA,
	// auxiliary adc results
	input wire logic [PPW_ADC_CH*PPW_ADC_W-1:0] ADC_DATA_IN,
	input wire logic [PPW_ADC_CH-1:0] ADC_VALID_IN,
	output logic [PPW_ADC_CH*PPW_ADC_W-1:0] ADC_DATA,
	// converter routing, three bits source and five bits pair per selector
	output logic [PPW_NUM_SEL*PPW_SRC_W-1:0] CONV_SOURCE,
	output logic [PPW_NUM_SEL*PPW_PAIR_W-1:0] CONV_SERIAL_PAIR,
	output logic [PPW_NUM_SEL-1:0] CONV_ACTIVE
);

	////////////////////////////////////////////////////////////////////////////
	// power enable register

	logic [PPW_POWER_W-1:0] power_q;
	logic power_wr;
	logic [PPW_SEL_W-1:0] sel_q [PPW_NUM_SEL];
	logic [15:0] rdata_d;
	logic [15:0] rdata_q;

	assign power_wr = REG_WR && (REG_ADDR == PPW_ADDR_POWER);

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			power_q <= PPW_POWER_RESET;
		end
		else if (power_wr)
		begin
			power_q <= REG_WDATA[PPW_POWER_W-1:0]; // only bits 4:0 are kept
		end
	end

	// enables leave straight from the register flops
	assign MIC_PAIR_HI_POWER_EN = power_q[PPW_BIT_MIC_HI];
	assign MIC_PAIR_LO_POWER_EN = power_q[PPW_BIT_MIC_LO];
	assign SPDIF_TRANSMIT_POWER_EN = power_q[PPW_BIT_SPDIF_TX];
	assign SPDIF_RECEIVE_POWER_EN = power_q[PPW_BIT_SPDIF_RX];
	assign AUX_CONVERTER_POWER_EN = power_q[PPW_BIT_AUX_ADC];

	////////////////////////////////////////////////////////////////////////////
	// microphone sample holding, channels 0/1 on the low pair, 2/3 on the high

	logic [PPW_MIC_CH*PPW_MIC_W-1:0] mic_q;

	genvar m;
	generate
		for (m = 0; m < PPW_MIC_CH; m++)
		begin : g_mic
			logic mic_en;
			// pair select by channel number
			assign mic_en = (m >= 2) ? power_q[PPW_BIT_MIC_HI] : power_q[PPW_BIT_MIC_LO];
			always_ff @(posedge CLK_SYS or negedge RST_N)
			begin
				if (!RST_N)
				begin
					mic_q[m*PPW_MIC_W +: PPW_MIC_W] <= '0;
				end
				else if (mic_en && MIC_VALID_IN[m])
				begin
					mic_q[m*PPW_MIC_W +: PPW_MIC_W] <= MIC_DATA_IN[m*PPW_MIC_W +: PPW_MIC_W];
				end
			end
		end
	endgenerate

	assign MIC_DATA = mic_q;

	////////////////////////////////////////////////////////////////////////////
	// s/pdif transmitter pin

	logic tx_pin_q;
	logic tx_en_d;

	// a clear written at this edge already silences the pin, no stray cycle of line
	assign tx_en_d = power_wr ? REG_WDATA[PPW_BIT_SPDIF_TX] : power_q[PPW_BIT_SPDIF_TX];

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			tx_pin_q <= 1'b0;
		end
		else
		begin
			tx_pin_q <= tx_en_d & SPDIF_TX_LINE_IN; // low while off
		end
	end

	assign SPDIF_TX_PIN = tx_pin_q;

	////////////////////////////////////////////////////////////////////////////
	// s/pdif receiver: stream blocked from recovery while off

	logic rx_stream_q;
	logic [PPW_RX_W-1:0] rx_data_q;
	logic rx_en_d;

	// stream to recovery stops at the very edge the bit is cleared
	assign rx_en_d = power_wr ? REG_WDATA[PPW_BIT_SPDIF_RX] : power_q[PPW_BIT_SPDIF_RX];

	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rx_stream_q <= 1'b0;
		end
		else
		begin
			rx_stream_q <= rx_en_d & SPDIF_RX_PIN;
		end
	end

	// recovered word only moves while powered; resumes on re-enable
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rx_data_q <= '0;
		end
		else if (power_q[PPW_BIT_SPDIF_RX] && SPDIF_RX_VALID_IN)
		begin
			rx_data_q <= SPDIF_RX_DATA_IN;
		end
	end

	assign SPDIF_RX_STREAM = rx_stream_q;
	assign SPDIF_RX_DATA = rx_data_q;

	////////////////////////////////////////////////////////////////////////////
	// auxiliary adc results, held at last value while off

	logic [PPW_ADC_CH*PPW_ADC_W-1:0] adc_q;

	genvar a;
	generate
		for (a = 0; a < PPW_ADC_CH; a++)
		begin : g_adc
			always_ff @(posedge CLK_SYS or negedge RST_N)
			begin
				if (!RST_N)
				begin
					adc_q[a*PPW_ADC_W +: PPW_ADC_W] <= '0;
				end
				else if (power_q[PPW_BIT_AUX_ADC] && ADC_VALID_IN[a])
				begin
					adc_q[a*PPW_ADC_W +: PPW_ADC_W] <= ADC_DATA_IN[a*PPW_ADC_W +: PPW_ADC_W];
				end
			end
		end
	endgenerate

	assign ADC_DATA = adc_q;

	////////////////////////////////////////////////////////////////////////////
	// converter input selectors

	logic [PPW_NUM_SEL*PPW_SRC_W-1:0] src_q;
	logic [PPW_NUM_SEL*PPW_PAIR_W-1:0] pair_q;
	logic [PPW_NUM_SEL-1:0] active_q;

	genvar s;
	generate
		for (s = 0; s < PPW_NUM_SEL; s++)
		begin : g_sel
			logic sel_wr;
			logic [PPW_SRC_W-1:0] src_d;
			logic [PPW_PAIR_W-1:0] pair_d;
			logic active_d;

			assign sel_wr = REG_WR && (REG_ADDR == PPW_ADDR_SEL_BASE + 16'(s));

			always_ff @(posedge CLK_SYS or negedge RST_N)
			begin
				if (!RST_N)
				begin
					sel_q[s] <= PPW_SEL_RESET;
				end
				else if (sel_wr)
				begin
					sel_q[s] <= REG_WDATA[PPW_SEL_W-1:0]; // bits 15:8 dropped
				end
			end

			assign src_d = sel_q[s][PPW_SRC_LSB +: PPW_SRC_W];
			assign pair_d = sel_q[s][PPW_PAIR_LSB +: PPW_PAIR_W];

			// pair codes past 23 name no serial channel, so the converter idles
			always_comb
			begin
				case (src_d)
					PPW_SRC_SERIAL: active_d = (pair_d <= PPW_PAIR_MAX);
					PPW_SRC_CORE: active_d = 1'b1;
					PPW_SRC_SPDIF: active_d = 1'b1;
					PPW_SRC_MIC_LO: active_d = 1'b1;
					PPW_SRC_MIC_HI: active_d = 1'b1;
					default: active_d = 1'b0; // none and undefined codes
				endcase
			end

			// routing copies registered so the outputs are clean flops
			always_ff @(posedge CLK_SYS or negedge RST_N)
			begin
				if (!RST_N)
				begin
					src_q[s*PPW_SRC_W +: PPW_SRC_W] <= '0;
					pair_q[s*PPW_PAIR_W +: PPW_PAIR_W] <= '0;
					active_q[s] <= 1'b0;
				end
				else
				begin
					src_q[s*PPW_SRC_W +: PPW_SRC_W] <= src_d;
					pair_q[s*PPW_PAIR_W +: PPW_PAIR_W] <= pair_d;
					active_q[s] <= active_d;
				end
			end
		end
	endgenerate

	assign CONV_SOURCE = src_q;
	assign CONV_SERIAL_PAIR = pair_q;
	assign CONV_ACTIVE = active_q;

	////////////////////////////////////////////////////////////////////////////
	// read path, one cycle latency, unmapped reads give zero

	logic power_hit;
	logic sel_hit;
	logic [2:0] sel_idx;

	// index is the offset from the base, so the window need not sit on an eight-word boundary
	assign power_hit = (REG_ADDR == PPW_ADDR_POWER);
	assign sel_hit = (REG_ADDR >= PPW_ADDR_SEL_BASE) && (REG_ADDR <= PPW_ADDR_SEL_LAST);
	assign sel_idx = 3'(REG_ADDR - PPW_ADDR_SEL_BASE);

	always_comb
	begin
		rdata_d = 16'h0000;
		if (power_hit)
		begin
			rdata_d = {11'h000, power_q};
		end
		else if (sel_hit)
		begin
			rdata_d = {8'h00, sel_q[sel_idx]};
		end
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge CLK_SYS or negedge RST_N)
	begin
		if (!RST_N)
		begin
			rdata_q <= 16'h0000;
		end
		else if (REG_RD)
		begin
			rdata_q <= rdata_d;
		end
		else
		begin
			rdata_q <= 16'h0000;
		end
	end

	assign REG_RDATA = rdata_q;

endmodule // ppw_top

// file: tb/ppw_top_asserts.sv
// assertions on the power enable and converter select bank
`timescale 1ns/1ps
module ppw_top_asserts
	import ppw_pkg::*;
(
	// clock, reset, register port
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic [15:0] REG_ADDR,
	input wire logic [15:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [15:0] REG_RDATA,
	// enables and gated paths
	input wire logic MIC_PAIR_HI_POWER_EN,
	input wire logic MIC_PAIR_LO_POWER_EN,
	input wire logic SPDIF_TRANSMIT_POWER_EN,
	input wire logic SPDIF_RECEIVE_POWER_EN,
	input wire logic AUX_CONVERTER_POWER_EN,
	input wire logic SPDIF_TX_LINE_IN,
	input wire logic SPDIF_TX_PIN,
	input wire logic SPDIF_RX_PIN,
	input wire logic SPDIF_RX_STREAM,
	input wire logic [23:0] SPDIF_RX_DATA,
	input wire logic [95:0] MIC_DATA,
	input wire logic [59:0] ADC_DATA
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);
	logic [4:0] pw;
	logic pw_wr;
	assign pw = {MIC_PAIR_HI_POWER_EN, MIC_PAIR_LO_POWER_EN, SPDIF_TRANSMIT_POWER_EN,
		SPDIF_RECEIVE_POWER_EN, AUX_CONVERTER_POWER_EN};
	assign pw_wr = REG_WR && REG_ADDR == PPW_ADDR_POWER;
	////////////////////////////////////////////////////////////////////////////////
	chk_pwr_write: assert property (pw_wr |=> pw == $past(REG_WDATA[4:0]))
		else $error("power enables not written");
	chk_pwr_hold: assert property (!pw_wr |=> $stable(pw))
		else $error("power enables moved");
	chk_rdata_idle: assert property (!$past(REG_RD) |-> REG_RDATA == 16'h0000)
		else $error("read data outside read cycle");
	chk_tx_gate: assert property (SPDIF_TX_PIN ==
		(SPDIF_TRANSMIT_POWER_EN && $past(SPDIF_TX_LINE_IN)))
		else $error("tx pin not gated");
	chk_rx_gate: assert property (SPDIF_RX_STREAM ==
		(SPDIF_RECEIVE_POWER_EN && $past(SPDIF_RX_PIN)))
		else $error("rx stream not gated");
	chk_rxd_hold: assert property (!SPDIF_RECEIVE_POWER_EN |=> $stable(SPDIF_RX_DATA))
		else $error("rx word moved while off");
	chk_adc_hold: assert property (!AUX_CONVERTER_POWER_EN |=> $stable(ADC_DATA))
		else $error("adc moved while off");
	chk_mic_lo: assert property (!MIC_PAIR_LO_POWER_EN |=> $stable(MIC_DATA[47:0]))
		else $error("mic 0/1 moved while off");
	chk_mic_hi: assert property (!MIC_PAIR_HI_POWER_EN |=> $stable(MIC_DATA[95:48]))
		else $error("mic 2/3 moved while off");
endmodule // ppw_top_asserts

// file: tb/testbench.sv
// self-checking bench for the power enable and converter select bank
`timescale 1ns/1ps
module testbench;
	import ppw_pkg::*;
	logic CLK_SYS, RST_N, REG_WR, REG_RD;
	logic [15:0] REG_ADDR, REG_WDATA, REG_RDATA;
	logic MIC_PAIR_HI_POWER_EN, MIC_PAIR_LO_POWER_EN, SPDIF_TRANSMIT_POWER_EN;
	logic SPDIF_RECEIVE_POWER_EN, AUX_CONVERTER_POWER_EN;
	logic [95:0] MIC_DATA_IN, MIC_DATA;
	logic [3:0] MIC_VALID_IN;
	logic SPDIF_TX_LINE_IN, SPDIF_TX_PIN, SPDIF_RX_PIN, SPDIF_RX_VALID_IN, SPDIF_RX_STREAM;
	logic [23:0] SPDIF_RX_DATA_IN, SPDIF_RX_DATA;
	logic [59:0] ADC_DATA_IN, ADC_DATA;
	logic [5:0] ADC_VALID_IN;
	logic [23:0] CONV_SOURCE;
	logic [39:0] CONV_SERIAL_PAIR;
	logic [7:0] CONV_ACTIVE;
	int fail_count = 0;
	int cmp_count = 0;
	int cyc = 0;
	ppw_top DUT (.CLK_SYS, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
		.MIC_PAIR_HI_POWER_EN, .MIC_PAIR_LO_POWER_EN, .SPDIF_TRANSMIT_POWER_EN,
		.SPDIF_RECEIVE_POWER_EN, .AUX_CONVERTER_POWER_EN, .MIC_DATA_IN, .MIC_VALID_IN,
		.MIC_DATA, .SPDIF_TX_LINE_IN, .SPDIF_TX_PIN, .SPDIF_RX_PIN, .SPDIF_RX_DATA_IN,
		.SPDIF_RX_VALID_IN, .SPDIF_RX_STREAM, .SPDIF_RX_DATA, .ADC_DATA_IN, .ADC_VALID_IN,
		.ADC_DATA, .CONV_SOURCE, .CONV_SERIAL_PAIR, .CONV_ACTIVE);
	////////////////////////////////////////////////////////////////////////////////
	task automatic conclude();
		$display("compares %0d mismatches %0d", cmp_count, fail_count);
		if (fail_count == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [95:0] e, input logic [95:0] g);
		cmp_count++;
		if (g !== e)
		begin
			fail_count++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic wr(input logic [15:0] a, input logic [15:0] d);
		@(posedge CLK_SYS);
		REG_WR <= 1'b1;
		REG_ADDR <= a;
		REG_WDATA <= d;
		@(posedge CLK_SYS);
		REG_WR <= 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [15:0] q);
		@(posedge CLK_SYS);
		REG_RD <= 1'b1;
		REG_ADDR <= a;
		@(posedge CLK_SYS);
		REG_RD <= 1'b0;
		@(negedge CLK_SYS);
		q = REG_RDATA;
	endtask
	// expected routing validity; pairs past 23 name no serial channels
	function automatic logic act(input logic [7:0] s);
		return s[2:0] inside {[3'h1:3'h5]} && (s[2:0] != 3'h1 || s[7:3] <= PPW_PAIR_MAX);
	endfunction
	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		CLK_SYS = 1'b0;
		forever #12.5 CLK_SYS = ~CLK_SYS;
	end
	always @(posedge CLK_SYS)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			fail_count++;
			conclude();
		end
	end
	initial
	begin
		logic [15:0] q, d;
		logic [15:0] sel [8];
		logic [23:0] cod;
		logic [95:0] mi, em;
		logic [59:0] ai, ea;
		logic [23:0] ri, er;
		logic [4:0] p;
		logic tl;
		{RST_N, REG_WR, REG_RD, REG_ADDR, REG_WDATA, MIC_DATA_IN, MIC_VALID_IN} = '0;
		{SPDIF_TX_LINE_IN, SPDIF_RX_PIN, SPDIF_RX_DATA_IN, SPDIF_RX_VALID_IN} = '0;
		{ADC_DATA_IN, ADC_VALID_IN, em, ea, er} = '0;
		cod = {3'h0, 3'h5, 3'h4, 3'h3, 3'h2, 3'h6, 3'h1, 3'h1};
		void'($urandom(32));
		repeat (6) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		rd(PPW_ADDR_POWER, q);
		chk("power", 16'h0000, q);
		wr(PPW_ADDR_POWER, 16'hFFFF);
		rd(PPW_ADDR_POWER, q);
		chk("power", 16'h001F, q);
		for (int n = 0; n < 8; n++)
		begin
			rd(PPW_ADDR_SEL_BASE + 16'(n), q);
			chk("sel", 16'h0000, q);
			d = 16'($urandom);
			d[2:0] = cod[n*3+:3];
			if (n < 2)
				d[7:3] = 5'h17 + 5'(n);
			sel[n] = d;
			wr(PPW_ADDR_SEL_BASE + 16'(n), d);
		end
		wr(16'hF108, 16'hFFFF);
		wr(16'hF050, 16'hFFFF);
		rd(16'hF108, q);
		chk("unmapped", 16'h0000, q);
		rd(PPW_ADDR_POWER, q);
		chk("power", 16'h001F, q);
		for (int n = 0; n < 8; n++)
		begin
			rd(PPW_ADDR_SEL_BASE + 16'(n), q);
			chk("sel", {8'h00, sel[n][7:0]}, q);
			chk("src", sel[n][2:0], CONV_SOURCE[n*3+:3]);
			chk("pair", sel[n][7:3], CONV_SERIAL_PAIR[n*5+:5]);
			chk("act", act(sel[n][7:0]), CONV_ACTIVE[n]);
		end
		$display("test registers done");
		// first pass all off, second all on, then random mixes
		for (int i = 0; i < 10; i++)
		begin
			p = i == 0 ? 5'h00 : i == 1 ? 5'h1F : 5'($urandom);
			wr(PPW_ADDR_POWER, {11'h000, p});
			mi = {$urandom, $urandom, $urandom};
			ai = 60'({$urandom, $urandom});
			ri = 24'($urandom);
			tl = 1'($urandom);
			@(posedge CLK_SYS);
			{MIC_DATA_IN, ADC_DATA_IN, SPDIF_RX_DATA_IN} <= {mi, ai, ri};
			{MIC_VALID_IN, ADC_VALID_IN, SPDIF_RX_VALID_IN} <= 11'h7FF;
			{SPDIF_TX_LINE_IN, SPDIF_RX_PIN} <= {tl, ~tl};
			@(posedge CLK_SYS);
			{MIC_VALID_IN, ADC_VALID_IN, SPDIF_RX_VALID_IN} <= 11'h000;
			@(negedge CLK_SYS);
			em[47:0] = p[3] ? mi[47:0] : em[47:0];
			em[95:48] = p[4] ? mi[95:48] : em[95:48];
			ea = p[0] ? ai : ea;
			er = p[1] ? ri : er;
			chk("pwr", p, {MIC_PAIR_HI_POWER_EN, MIC_PAIR_LO_POWER_EN, SPDIF_TRANSMIT_POWER_EN,
				SPDIF_RECEIVE_POWER_EN, AUX_CONVERTER_POWER_EN});
			chk("mic", em, MIC_DATA);
			chk("adc", ea, ADC_DATA);
			chk("rx", er, SPDIF_RX_DATA);
			chk("rxs", p[1] & ~tl, SPDIF_RX_STREAM);
			chk("tx", p[2] & tl, SPDIF_TX_PIN);
		end
		$display("test gating done");
		// reset again in mid-run, with every block powered and the selectors loaded
		wr(PPW_ADDR_POWER, 16'h001F);
		@(posedge CLK_SYS);
		RST_N <= 1'b0;
		repeat (2) @(posedge CLK_SYS);
		RST_N <= 1'b1;
		rd(PPW_ADDR_POWER, q);
		chk("power", 16'h0000, q);
		chk("pwr", 5'h00, {MIC_PAIR_HI_POWER_EN, MIC_PAIR_LO_POWER_EN, SPDIF_TRANSMIT_POWER_EN,
			SPDIF_RECEIVE_POWER_EN, AUX_CONVERTER_POWER_EN});
		rd(PPW_ADDR_SEL_BASE, q);
		chk("sel", 16'h0000, q);
		chk("act", 8'h00, CONV_ACTIVE);
		$display("test reset done");
		conclude();
	end
endmodule // testbench

bind ppw_top ppw_top_asserts u_chk (.CLK_SYS, .RST_N, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD,
	.REG_RDATA, .MIC_PAIR_HI_POWER_EN, .MIC_PAIR_LO_POWER_EN, .SPDIF_TRANSMIT_POWER_EN,
	.SPDIF_RECEIVE_POWER_EN, .AUX_CONVERTER_POWER_EN, .SPDIF_TX_LINE_IN, .SPDIF_TX_PIN,
	.SPDIF_RX_PIN, .SPDIF_RX_STREAM, .SPDIF_RX_DATA, .MIC_DATA, .ADC_DATA);
